// ==== core/ebi_top.sv ====
// edge, merged and tick interrupt request logic with AXI4-Lite registers
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - selected pin edge sets external flag
// - external call needs global and external enable
// - edge select: rising, falling or both
// - edge select also offers disabled choice
// - pin is interrupt input only when enabled
// - pull-high selection stays valid as interrupt
// - external service clears global enable
// - two merged requests from timer compares
// - merged flag sets when member flag sets
// - merged call needs enable and stack room
// - merged service clears flag and global enable
// - member timer flags cleared only by software
// - tick flag sets on its divider overflow
// - tick call needs enables and stack room
// - tick service clears flag and global enable
// - tick clock divided by programmable ratio
// - bits 5:4 pick tick1 period 4096 up
// - no acknowledge while return stack full
// - any rising bit of the flags register wakes the device
// - global enable clear blocks every call
module ebi_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_pin,
	input wire logic tick_alt_oscillator,
	input wire logic [3:0] tm_cmp_pulse,
	input wire logic stack_full,
	input wire logic call_ack,
	output logic call_req,
	output logic [2:0] call_vec,
	output logic wake,
	output logic ext_pin_is_irq,
	output logic pin_pullup_en
);
	// software state
	logic global_irq_enable_q;
	logic ext_en_q;
	logic [1:0] ext_edge_select_q;
	logic pullup_q;
	logic [3:0] en_q;
	logic [ebi_pkg::FLAG_W-1:0] flags_q;
	logic [ebi_pkg::FLAG_W-1:0] flags_d;
	logic [ebi_pkg::TM_SRC_W-1:0] tm_flags_q;
	logic [ebi_pkg::TM_SRC_W-1:0] tm_flags_d;
	logic [7:0] time_base_control_q;

	// bus slave state
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] aw_addr_q;
	logic [7:0] w_data_q;
	logic w_strb0_q;

	// synchronisers
	logic pin_s1_q;
	logic pin_s2_q;
	logic pin_s3_q;
	logic alt_s1_q;
	logic alt_s2_q;
	logic alt_s3_q;
	logic [1:0] sys_div_q;

	// write side decode
	logic wr_fire;
	logic wr_ok;
	logic wr_ctrl;
	logic wr_flags;
	logic wr_en;
	logic wr_tm;
	logic wr_tbc;
	logic wr_mapped;
	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wr_ok = wr_fire && w_strb0_q;
	assign wr_ctrl = wr_ok && (aw_addr_q == ebi_pkg::CTRL_OFS);
	assign wr_flags = wr_ok && (aw_addr_q == ebi_pkg::FLAGS_OFS);
	assign wr_en = wr_ok && (aw_addr_q == ebi_pkg::ENABLE_OFS);
	assign wr_tm = wr_ok && (aw_addr_q == ebi_pkg::TM_FLAGS_OFS);
	assign wr_tbc = wr_ok && (aw_addr_q == ebi_pkg::TBC_OFS);
	assign wr_mapped = (aw_addr_q == ebi_pkg::CTRL_OFS)
		|| (aw_addr_q == ebi_pkg::FLAGS_OFS)
		|| (aw_addr_q == ebi_pkg::ENABLE_OFS)
		|| (aw_addr_q == ebi_pkg::TM_FLAGS_OFS)
		|| (aw_addr_q == ebi_pkg::TBC_OFS)
		|| (aw_addr_q == ebi_pkg::STATUS_OFS);

	// external edge detection on the synchronised pin
	logic rise;
	logic fall;
	logic edge_hit;
	assign rise = pin_s2_q && !pin_s3_q;
	assign fall = !pin_s2_q && pin_s3_q;
	assign edge_hit = ext_en_q &&
		(((ext_edge_select_q == ebi_pkg::EDGE_RISE) && rise) ||
		((ext_edge_select_q == ebi_pkg::EDGE_FALL) && fall) ||
		((ext_edge_select_q == ebi_pkg::EDGE_BOTH) && (rise || fall)));
	// EDGE_OFF matches no term above

	// merged requests from timer member pulses
	logic [1:0] mf_set;
	assign mf_set[0] = |tm_cmp_pulse[1:0];
	assign mf_set[1] = |tm_cmp_pulse[3:2];

	// time base clock and dividers
	logic tb_on;
	logic tb_tick;
	logic tb0_ovf;
	logic tb1_ovf;
	assign tb_on = time_base_control_q[ebi_pkg::TBC_ON_BIT];
	assign tb_tick = time_base_control_q[ebi_pkg::TBC_CK_BIT] ?
		(sys_div_q == ebi_pkg::SYS_DIV4_LAST) :
		(alt_s2_q && !alt_s3_q);

	ebi_tick_div #(
		.MIN_EXP(ebi_pkg::TB0_MIN_EXP),
		.SEL_W(3)
	) u_tick0 (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(tb_on),
		.tick(tb_tick),
		.sel(time_base_control_q[ebi_pkg::TBC_P0_LSB +: 3]),
		.ovf(tb0_ovf)
	);

	ebi_tick_div #(
		.MIN_EXP(ebi_pkg::TB1_MIN_EXP),
		.SEL_W(2)
	) u_tick1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(tb_on),
		.tick(tb_tick),
		.sel(time_base_control_q[ebi_pkg::TBC_P1_LSB +: 2]),
		.ovf(tb1_ovf)
	);

	// hardware set sources, one per flag
	logic [ebi_pkg::FLAG_W-1:0] hw_set;
	assign hw_set[ebi_pkg::FLAG_EXT_BIT] = edge_hit;
	assign hw_set[ebi_pkg::FLAG_MF0_BIT] = mf_set[0];
	assign hw_set[ebi_pkg::FLAG_MF1_BIT] = mf_set[1];
	assign hw_set[ebi_pkg::FLAG_TB0_BIT] = tb0_ovf;
	assign hw_set[ebi_pkg::FLAG_TB1_BIT] = tb1_ovf;

	// per-source readiness and fixed priority
	logic [ebi_pkg::FLAG_W-1:0] ready;
	logic can_call;
	logic [2:0] pick_vec;
	logic any_ready;
	assign ready[ebi_pkg::FLAG_EXT_BIT] =
		flags_q[ebi_pkg::FLAG_EXT_BIT] && ext_en_q;
	assign ready[ebi_pkg::FLAG_MF0_BIT] =
		flags_q[ebi_pkg::FLAG_MF0_BIT] && en_q[ebi_pkg::EN_MF0_BIT];
	assign ready[ebi_pkg::FLAG_MF1_BIT] =
		flags_q[ebi_pkg::FLAG_MF1_BIT] && en_q[ebi_pkg::EN_MF1_BIT];
	assign ready[ebi_pkg::FLAG_TB0_BIT] =
		flags_q[ebi_pkg::FLAG_TB0_BIT] && en_q[ebi_pkg::EN_TB0_BIT];
	assign ready[ebi_pkg::FLAG_TB1_BIT] =
		flags_q[ebi_pkg::FLAG_TB1_BIT] && en_q[ebi_pkg::EN_TB1_BIT];
	assign any_ready = |ready;
	assign can_call = global_irq_enable_q &&
		!stack_full && !call_ack;
	assign pick_vec =
		ready[ebi_pkg::FLAG_EXT_BIT] ? ebi_pkg::VEC_EXT :
		ready[ebi_pkg::FLAG_MF0_BIT] ? ebi_pkg::VEC_MF0 :
		ready[ebi_pkg::FLAG_MF1_BIT] ? ebi_pkg::VEC_MF1 :
		ready[ebi_pkg::FLAG_TB0_BIT] ? ebi_pkg::VEC_TB0 :
		ebi_pkg::VEC_TB1;

	// service clears only the flag of the vector taken
	logic ack_ok;
	logic [ebi_pkg::FLAG_W-1:0] ack_clr;
	assign ack_ok = call_ack && call_req;
	assign ack_clr = ack_ok ?
		ebi_pkg::FLAG_W'(5'h01 << call_vec) : '0;

	// set wins over software write and over service clear
	assign flags_d = hw_set |
		((wr_flags ? w_data_q[ebi_pkg::FLAG_W-1:0] : flags_q) & ~ack_clr);
	// member flags ignore service, software clears them
	assign tm_flags_d = tm_cmp_pulse |
		(wr_tm ? w_data_q[ebi_pkg::TM_SRC_W-1:0] : tm_flags_q);

	// read side decode
	logic rd_take;
	logic rd_mapped;
	logic [31:0] rd_word;
	assign rd_take = s_axi_arvalid && s_axi_arready;
	assign rd_mapped = (s_axi_araddr == ebi_pkg::CTRL_OFS)
		|| (s_axi_araddr == ebi_pkg::FLAGS_OFS)
		|| (s_axi_araddr == ebi_pkg::ENABLE_OFS)
		|| (s_axi_araddr == ebi_pkg::TM_FLAGS_OFS)
		|| (s_axi_araddr == ebi_pkg::TBC_OFS)
		|| (s_axi_araddr == ebi_pkg::STATUS_OFS);
	assign rd_word =
		(s_axi_araddr == ebi_pkg::CTRL_OFS) ? {27'h0, pullup_q,
			ext_edge_select_q, ext_en_q, global_irq_enable_q} :
		(s_axi_araddr == ebi_pkg::FLAGS_OFS) ? {27'h0, flags_q} :
		(s_axi_araddr == ebi_pkg::ENABLE_OFS) ? {28'h0, en_q} :
		(s_axi_araddr == ebi_pkg::TM_FLAGS_OFS) ? {28'h0, tm_flags_q} :
		(s_axi_araddr == ebi_pkg::TBC_OFS) ?
			{24'h0, time_base_control_q} :
		(s_axi_araddr == ebi_pkg::STATUS_OFS) ?
			{27'h0, call_vec, call_req, pin_s2_q} :
		32'h0;

	// input synchronisers and sysclk/4 prescaler
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
			alt_s1_q <= 1'b0;
			alt_s2_q <= 1'b0;
			alt_s3_q <= 1'b0;
			sys_div_q <= 2'h0;
		end else begin
			pin_s1_q <= ext_pin;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			alt_s1_q <= tick_alt_oscillator;
			alt_s2_q <= alt_s1_q;
			alt_s3_q <= alt_s2_q;
			sys_div_q <= sys_div_q + 2'h1;
		end
	end

	// control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			global_irq_enable_q <= 1'b0;
			ext_en_q <= 1'b0;
			ext_edge_select_q <= ebi_pkg::EDGE_OFF;
			pullup_q <= 1'b0;
			en_q <= 4'h0;
			time_base_control_q <= ebi_pkg::TBC_RESET;
		end else begin
			if (ack_ok) begin
				global_irq_enable_q <= 1'b0;
			end else if (wr_ctrl) begin
				global_irq_enable_q <= w_data_q[ebi_pkg::CTRL_GIE_BIT];
			end
			if (wr_ctrl) begin
				ext_en_q <= w_data_q[ebi_pkg::CTRL_EXT_EN_BIT];
				ext_edge_select_q <= w_data_q[ebi_pkg::CTRL_EDGE_LSB +: 2];
				pullup_q <= w_data_q[ebi_pkg::CTRL_PULLUP_BIT];
			end
			if (wr_en) begin
				en_q <= w_data_q[3:0];
			end
			if (wr_tbc) begin
				time_base_control_q <= w_data_q & ebi_pkg::TBC_RW_MASK;
			end
		end
	end

	// flags, call request and wake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= '0;
			tm_flags_q <= '0;
			call_req <= 1'b0;
			call_vec <= ebi_pkg::VEC_EXT;
			wake <= 1'b0;
			ext_pin_is_irq <= 1'b0;
			pin_pullup_en <= 1'b0;
		end else begin
			flags_q <= flags_d;
			tm_flags_q <= tm_flags_d;
			call_req <= can_call && any_ready;
			call_vec <= pick_vec;
			wake <= |(flags_d & ~flags_q);
			ext_pin_is_irq <= ext_en_q;
			pin_pullup_en <= pullup_q;
		end
	end

	// AXI4-Lite write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 8'h00;
			w_strb0_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ebi_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready &&
				!s_axi_bvalid;
			s_axi_wready <= !w_have_q && !s_axi_wready &&
				!s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata[7:0];
				w_strb0_q <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ?
					ebi_pkg::RESP_OKAY : ebi_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= ebi_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
				!rd_take;
			if (rd_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_mapped ?
					ebi_pkg::RESP_OKAY : ebi_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : ebi_top

// ==== core/ebi_pkg.sv ====
// constants for the edge, merged and tick interrupt block
package ebi_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] FLAGS_OFS = 8'h04;
	localparam logic [7:0] ENABLE_OFS = 8'h08;
	localparam logic [7:0] TM_FLAGS_OFS = 8'h0C;
	localparam logic [7:0] TBC_OFS = 8'h10;
	localparam logic [7:0] STATUS_OFS = 8'h14;
	// control register fields
	localparam int CTRL_GIE_BIT = 0;
	localparam int CTRL_EXT_EN_BIT = 1;
	localparam int CTRL_EDGE_LSB = 2;
	localparam int CTRL_PULLUP_BIT = 4;
	// flag register fields
	localparam int FLAG_EXT_BIT = 0;
	localparam int FLAG_MF0_BIT = 1;
	localparam int FLAG_MF1_BIT = 2;
	localparam int FLAG_TB0_BIT = 3;
	localparam int FLAG_TB1_BIT = 4;
	localparam int FLAG_W = 5;
	// enable register fields
	localparam int EN_MF0_BIT = 0;
	localparam int EN_MF1_BIT = 1;
	localparam int EN_TB0_BIT = 2;
	localparam int EN_TB1_BIT = 3;
	// timer module member flags: two per merged request
	localparam int TM_SRC_W = 4;
	// time base control fields
	localparam int TBC_ON_BIT = 7;
	localparam int TBC_CK_BIT = 6;
	localparam int TBC_P1_LSB = 4;
	localparam int TBC_P0_LSB = 0;
	localparam logic [7:0] TBC_RESET = 8'h37;
	localparam logic [7:0] TBC_RW_MASK = 8'hF7;
	// divider exponents: tick0 256..32768, tick1 4096..32768
	localparam int TB0_MIN_EXP = 8;
	localparam int TB1_MIN_EXP = 12;
	localparam int TB_CNT_W = 15;
	localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
	// edge select codes
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// call vectors
	localparam logic [2:0] VEC_EXT = 3'h0;
	localparam logic [2:0] VEC_MF0 = 3'h1;
	localparam logic [2:0] VEC_MF1 = 3'h2;
	localparam logic [2:0] VEC_TB0 = 3'h3;
	localparam logic [2:0] VEC_TB1 = 3'h4;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ebi_pkg

// ==== core/ebi_tick_div.sv ====
// one time base divider with selectable power-of-two period
`timescale 1ns/1ps
module ebi_tick_div #(
	parameter int MIN_EXP = 8,
	parameter int SEL_W = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic tick,
	input wire logic [SEL_W-1:0] sel,
	output logic ovf
);
	logic [ebi_pkg::TB_CNT_W-1:0] cnt_q;
	logic [ebi_pkg::TB_CNT_W-1:0] mask;
	logic [4:0] exp_w;
	logic hit;

	assign exp_w = 5'(MIN_EXP) + 5'(sel);
	assign mask = ebi_pkg::TB_CNT_W'((32'h1 << exp_w) - 32'h1);
	assign hit = tick && ((cnt_q & mask) == mask);

	// counter stops and clears while the dividers are off
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_q <= '0;
			ovf <= 1'b0;
		end else begin
			if (tick) begin
				cnt_q <= cnt_q + 1'b1;
			end
			ovf <= hit;
		end
	end
endmodule : ebi_tick_div

// ==== bench/ebi_core_model.sv ====
// processor core model answering call requests
`timescale 1ns/1ps
module ebi_core_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic slow,
	input wire logic call_req,
	input wire logic [2:0] call_vec,
	output logic call_ack,
	output logic [2:0] taken_vec,
	output int taken_cnt
);
	int wait_q;
	// ack only while the request stands, prompt or slow
	always_ff @(posedge aclk) begin
		call_ack <= 1'b0;
		wait_q <= 0;
		if (!aresetn) begin
			taken_cnt <= 0;
			taken_vec <= 3'h7;
		end else if (call_req && !call_ack) begin
			wait_q <= wait_q + 1;
			if (wait_q >= (slow ? 5 : 0)) begin
				call_ack <= 1'b1;
				wait_q <= 0;
				taken_vec <= call_vec;
				taken_cnt <= taken_cnt + 1;
			end
		end
	end
endmodule : ebi_core_model

// ==== bench/ebi_checker.sv ====
// port assertions for the interrupt block
`timescale 1ns/1ps
module ebi_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic stack_full,
	input wire logic call_ack,
	input wire logic call_req,
	input wire logic [2:0] call_vec,
	input wire logic ext_pin_is_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_served;
		call_req && call_ack;
	endsequence
	chk_stack_block: assert property (stack_full |=> !call_req)
		else $error("call raised with stack full");
	chk_serve_clear: assert property (s_served |=> !call_req [*2])
		else $error("call kept after service");
	chk_vec_legal: assert property (call_req |-> call_vec <= 3'h4)
		else $error("call vector out of range");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	chk_read_lat: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer late");
	chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken while answering");
	chk_pin_mode: assert property ($changed(ext_pin_is_irq) |->
		$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
		else $error("pin mode changed without write");
endmodule : ebi_checker
bind ebi_top ebi_checker u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.stack_full(stack_full), .call_ack(call_ack), .call_req(call_req),
	.call_vec(call_vec), .ext_pin_is_irq(ext_pin_is_irq));

// ==== bench/ebi_top_test.sv ====
// self-checking bench for the interrupt block
`timescale 1ns/1ps
module ebi_top_test;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, ext_pin, tick_alt_oscillator;
	logic stack_full, slow, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, call_req, call_ack, wake;
	logic ext_pin_is_irq, pin_pullup_en;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] tm_cmp_pulse;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [2:0] s_axi_awprot = 3'h0;
	logic [2:0] s_axi_arprot = 3'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, b;
	logic [2:0] call_vec, taken_vec;
	int taken_cnt, err_total, total_checks, cyc, wakes, w0;
	int exp_vec[$];
	ebi_top DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .ext_pin(ext_pin),
		.tick_alt_oscillator(tick_alt_oscillator),
		.tm_cmp_pulse(tm_cmp_pulse), .stack_full(stack_full),
		.call_ack(call_ack), .call_req(call_req),
		.call_vec(call_vec), .wake(wake),
		.ext_pin_is_irq(ext_pin_is_irq),
		.pin_pullup_en(pin_pullup_en));
	ebi_core_model u_core (.aclk(aclk), .aresetn(aresetn), .slow(slow),
		.call_req(call_req), .call_vec(call_vec), .call_ack(call_ack),
		.taken_vec(taken_vec), .taken_cnt(taken_cnt));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		tick_alt_oscillator = 1'b0;
		forever #43 tick_alt_oscillator = ~tick_alt_oscillator;
	end
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		wakes <= wakes + int'(wake);
		if (cyc == 45000) begin
			err_total++;
			conclude();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task tk(input int n);
		repeat (n) @(posedge aclk);
	endtask : tk
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, t;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(negedge aclk);
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
			@(posedge aclk);
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			t = s_axi_bvalid;
			wr_resp = s_axi_bresp;
			@(posedge aclk);
		end while (!t);
		s_axi_bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		logic t;
		logic [31:0] d;
		logic [1:0] r;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			t = s_axi_arready;
			@(posedge aclk);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			t = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
		end while (!t);
		s_axi_rready <= 1'b0;
		chk(d, e);
		chk(32'(r), 32'(ebi_pkg::RESP_OKAY));
	endtask : rd
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, ext_pin, stack_full, slow} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, tm_cmp_pulse} = 52'h0;
		{cyc, wakes, err_total, total_checks} = 128'h0;
		void'($urandom(38));
		tk(16);
		aresetn <= 1'b1;
		tk(1);
		rd(ebi_pkg::TBC_OFS, 32'h37);
		wr(ebi_pkg::TBC_OFS, 32'hFF);
		rd(ebi_pkg::TBC_OFS, 32'hF7);
		wr(8'h40, 32'h1);
		chk(32'(wr_resp), 32'(ebi_pkg::RESP_SLVERR));
		$display("register test done");
		w0 = wakes;
		for (int e = 0; e < 4; e++) begin
			wr(ebi_pkg::CTRL_OFS, 32'(e % 2 * 16 + e * 4 + 2));
			tk(1);
			chk(32'(pin_pullup_en), 32'(e % 2));
			chk(32'(ext_pin_is_irq), 32'h1);
			wr(ebi_pkg::FLAGS_OFS, 32'h0);
			ext_pin <= 1'b1;
			tk(6);
			rd(ebi_pkg::FLAGS_OFS, 32'(e % 2));
			wr(ebi_pkg::FLAGS_OFS, 32'h0);
			ext_pin <= 1'b0;
			tk(6);
			rd(ebi_pkg::FLAGS_OFS, 32'(e / 2));
		end
		chk(32'(wakes - w0), 32'h4);
		wr(ebi_pkg::CTRL_OFS, 32'h0C);
		wr(ebi_pkg::FLAGS_OFS, 32'h0);
		chk(32'(ext_pin_is_irq), 32'h0);
		ext_pin <= 1'b1;
		tk(6);
		rd(ebi_pkg::FLAGS_OFS, 32'h0);
		ext_pin <= 1'b0;
		$display("edge test done");
		exp_vec = {ebi_pkg::VEC_EXT, ebi_pkg::VEC_MF0};
		stack_full <= 1'b1;
		slow <= 1'($urandom % 2);
		b = 2'(1 << ($urandom % 2));
		wr(ebi_pkg::ENABLE_OFS, 32'h1);
		wr(ebi_pkg::CTRL_OFS, 32'h07);
		ext_pin <= 1'b1;
		tm_cmp_pulse <= {2'h0, b};
		tk(1);
		tm_cmp_pulse <= 4'h0;
		tk(20);
		chk(32'(call_req), 32'h0);
		rd(ebi_pkg::FLAGS_OFS, 32'h3);
		stack_full <= 1'b0;
		while (taken_cnt < 1) tk(1);
		chk(32'(taken_vec), 32'(exp_vec.pop_front()));
		rd(ebi_pkg::CTRL_OFS, 32'h06);
		rd(ebi_pkg::FLAGS_OFS, 32'h2);
		wr(ebi_pkg::CTRL_OFS, 32'h07);
		while (taken_cnt < 2) tk(1);
		chk(32'(taken_vec), 32'(exp_vec.pop_front()));
		rd(ebi_pkg::FLAGS_OFS, 32'h0);
		rd(ebi_pkg::CTRL_OFS, 32'h06);
		rd(ebi_pkg::TM_FLAGS_OFS, 32'(b));
		$display("call test done");
		wr(ebi_pkg::TBC_OFS, 32'h40);
		wr(ebi_pkg::FLAGS_OFS, 32'h0);
		tk(1200);
		rd(ebi_pkg::FLAGS_OFS, 32'h0);
		wr(ebi_pkg::TBC_OFS, 32'h80);
		tk(2000);
		rd(ebi_pkg::FLAGS_OFS, 32'h0);
		tk(400);
		rd(ebi_pkg::FLAGS_OFS, 32'h8);
		wr(ebi_pkg::TBC_OFS, 32'h0);
		wr(ebi_pkg::FLAGS_OFS, 32'h0);
		wr(ebi_pkg::TBC_OFS, 32'hD0);
		tk(990);
		rd(ebi_pkg::FLAGS_OFS, 32'h0);
		tk(60);
		rd(ebi_pkg::FLAGS_OFS, 32'h8);
		tk(31600);
		rd(ebi_pkg::FLAGS_OFS, 32'h8);
		tk(200);
		rd(ebi_pkg::FLAGS_OFS, 32'h18);
		wr(ebi_pkg::TBC_OFS, 32'h0);
		wr(ebi_pkg::ENABLE_OFS, 32'h4);
		tk(3);
		chk(32'(call_req), 32'h0);
		wr(ebi_pkg::CTRL_OFS, 32'h01);
		while (taken_cnt < 3) tk(1);
		chk(32'(taken_vec), 32'(ebi_pkg::VEC_TB0));
		rd(ebi_pkg::FLAGS_OFS, 32'h10);
		rd(ebi_pkg::CTRL_OFS, 32'h0);
		$display("tick test done");
		conclude();
	end
endmodule : ebi_top_test
